// ===== hdl/codec_regs_cfg.svh
// constants of the codec gain, time-slot and io pin register bank
// assumes one clock domain and a byte-wide command port in front of it
`ifndef CODEC_REGS_CFG_SVH
`define CODEC_REGS_CFG_SVH

`define CMD_READ        4'ha
`define CMD_WRITE       4'hb

`define ADDR_MODE       4'h0
`define ADDR_TX_COARSE  4'h1
`define ADDR_TX_FINE    4'h2
`define ADDR_RX_COARSE  4'h3
`define ADDR_RX_FINE    4'h4
`define ADDR_RXS        4'h5
`define ADDR_RXD        4'h6
`define ADDR_TXS        4'h7
`define ADDR_TXD        4'h8
`define ADDR_RSVD       4'h9
`define ADDR_GPIO       4'ha

`define GPIO_DIR_LSB    4
`define RESET_FIELD     8'h00
`define READ_ZERO       8'h00

`define COARSE_MAX      5'sh0c
`define COARSE_MIN      5'sh14
`define FINE_MAX        4'h9
`define TENTHS_PER_DB   9'sh00a

`endif

// ===== hdl/codec_regs_pkg.sv
// types shared by the register bank and its gain calculator
// assumes the constants header for all figures
package codec_regs_pkg;
	typedef logic [7:0]        byte_t;
	typedef logic signed [4:0] db_t;
	typedef logic [3:0]        tenth_t;
	typedef logic signed [8:0] gain_t;
	typedef logic [6:0]        slot_t;
	typedef logic [2:0]        delay_t;
	typedef enum logic [1:0] {
		cmd_none,
		cmd_read,
		cmd_write
	} cmd_kind_t;
endpackage

// ===== hdl/gain_if.sv
// carries one gain path between the bank and its calculator
// assumes both ends in the same clock domain
`timescale 1ns/1ps
interface gain_if;
	import codec_regs_pkg::*;
	logic [4:0] coarse;
	tenth_t     fine;
	db_t        coarse_sat;
	tenth_t     fine_sat;
	gain_t      total;
	modport calc (input coarse, input fine, output coarse_sat, output fine_sat, output total);
	modport user (output coarse, output fine, input coarse_sat, input fine_sat, input total);
endinterface

// ===== hdl/gain_calc.sv
// saturates one coarse and one fine gain field and sums them in tenths of a db
// assumes raw fields held in registers by the bank
`timescale 1ns/1ps
`include "codec_regs_cfg.svh"
module gain_calc (
	gain_if.calc g
);
	import codec_regs_pkg::*;

	db_t    c;
	db_t    c_sat;
	tenth_t f_sat;

	always_comb begin
		c = $signed(g.coarse);
		if (c > `COARSE_MAX) begin
			c_sat = `COARSE_MAX;
		end else if (c < `COARSE_MIN) begin
			c_sat = `COARSE_MIN;
		end else begin
			c_sat = c;
		end
		if (g.fine > `FINE_MAX) begin
			f_sat = `FINE_MAX;
		end else begin
			f_sat = g.fine;
		end
	end

	assign g.coarse_sat = c_sat;
	assign g.fine_sat   = f_sat;
	// sum in tenths
	assign g.total = gain_t'(gain_t'(c_sat) * `TENTHS_PER_DB) + gain_t'({5'h00, f_sat});
endmodule // gain_calc

// ===== hdl/codec_regs.sv
// register bank: gains, pcm slot and bit delay selections, io pin control
// assumes commands already deframed into a type/address byte plus data byte
`timescale 1ns/1ps
`include "codec_regs_cfg.svh"
module codec_regs #(
	parameter int IO_PINS = 4
) (
	input  wire logic                  clk_i,
	input  wire logic                  nrst_i,
	input  wire logic                  en_i,
	input  wire logic                  cmd_valid_i,
	input  wire codec_regs_pkg::byte_t cmd_byte_i,
	input  wire codec_regs_pkg::byte_t wr_data_i,
	input  wire logic [IO_PINS-1:0]    io_in_i,
	output codec_regs_pkg::byte_t      rd_data_o,
	output logic                       rd_valid_o,
	output codec_regs_pkg::db_t        tx_gain_db_o,
	output codec_regs_pkg::tenth_t     tx_gain_tenth_o,
	output codec_regs_pkg::gain_t      tx_gain_total_o,
	output codec_regs_pkg::db_t        rx_gain_db_o,
	output codec_regs_pkg::tenth_t     rx_gain_tenth_o,
	output codec_regs_pkg::gain_t      rx_gain_total_o,
	output codec_regs_pkg::slot_t      rx_slot_o,
	output codec_regs_pkg::delay_t     rx_delay_o,
	output codec_regs_pkg::slot_t      tx_slot_o,
	output codec_regs_pkg::delay_t     tx_delay_o,
	output logic [IO_PINS-1:0]         io_out_o,
	output logic [IO_PINS-1:0]         io_oe_n_o
);
	import codec_regs_pkg::*;

	if (IO_PINS != 4) begin : g_pins_check
		$error("io pin control register holds exactly four pins");
	end

	// field registers
	logic [4:0]         tx_gain_coarse_field_q;
	logic [4:0]         tx_gain_coarse_field_d;
	tenth_t             tx_gain_fine_field_q;
	tenth_t             tx_gain_fine_field_d;
	logic [4:0]         rx_gain_coarse_field_q;
	logic [4:0]         rx_gain_coarse_field_d;
	tenth_t             rx_gain_fine_field_q;
	tenth_t             rx_gain_fine_field_d;
	slot_t              rx_slot_field_q;
	slot_t              rx_slot_field_d;
	delay_t             rx_delay_field_q;
	delay_t             rx_delay_field_d;
	slot_t              tx_slot_field_q;
	slot_t              tx_slot_field_d;
	delay_t             tx_delay_field_q;
	delay_t             tx_delay_field_d;
	logic [IO_PINS-1:0] io_dir_q;
	logic [IO_PINS-1:0] io_dir_d;
	logic [IO_PINS-1:0] io_data_q;
	logic [IO_PINS-1:0] io_data_d;

	// read answer and output registers
	byte_t              rd_data_q;
	byte_t              rd_data_d;
	logic               rd_valid_q;
	logic               rd_valid_d;
	db_t                tx_db_q;
	db_t                tx_db_d;
	tenth_t             tx_tenth_q;
	tenth_t             tx_tenth_d;
	gain_t              tx_total_q;
	gain_t              tx_total_d;
	db_t                rx_db_q;
	db_t                rx_db_d;
	tenth_t             rx_tenth_q;
	tenth_t             rx_tenth_d;
	gain_t              rx_total_q;
	gain_t              rx_total_d;
	slot_t              rx_slot_q;
	slot_t              rx_slot_d;
	delay_t             rx_delay_q;
	delay_t             rx_delay_d;
	slot_t              tx_slot_q;
	slot_t              tx_slot_d;
	delay_t             tx_delay_q;
	delay_t             tx_delay_d;
	logic [IO_PINS-1:0] io_out_q;
	logic [IO_PINS-1:0] io_out_d;
	logic [IO_PINS-1:0] io_oe_n_q;
	logic [IO_PINS-1:0] io_oe_n_d;

	cmd_kind_t          cmd_kind;
	logic [3:0]         cmd_addr;
	logic [IO_PINS-1:0] io_view;

	gain_if tx_g ();
	gain_if rx_g ();

	assign tx_g.coarse = tx_gain_coarse_field_q;
	assign tx_g.fine   = tx_gain_fine_field_q;
	assign rx_g.coarse = rx_gain_coarse_field_q;
	assign rx_g.fine   = rx_gain_fine_field_q;

	gain_calc u_tx_gain (
		.g (tx_g.calc)
	);

	gain_calc u_rx_gain (
		.g (rx_g.calc)
	);

	// command type nibble then address nibble
	always_comb begin
		cmd_addr = cmd_byte_i[3:0];
		cmd_kind = cmd_none;
		if (en_i && cmd_valid_i) begin
			if (cmd_byte_i[7:4] == `CMD_READ) begin
				cmd_kind = cmd_read;
			end else if (cmd_byte_i[7:4] == `CMD_WRITE) begin
				cmd_kind = cmd_write;
			end
		end
	end

	// inputs show live level, outputs the last written bit
	assign io_view = (io_data_q & io_dir_q) | (io_in_i & ~io_dir_q);

	// field register writes
	always_comb begin
		tx_gain_coarse_field_d = tx_gain_coarse_field_q;
		tx_gain_fine_field_d   = tx_gain_fine_field_q;
		rx_gain_coarse_field_d = rx_gain_coarse_field_q;
		rx_gain_fine_field_d   = rx_gain_fine_field_q;
		rx_slot_field_d        = rx_slot_field_q;
		rx_delay_field_d       = rx_delay_field_q;
		tx_slot_field_d        = tx_slot_field_q;
		tx_delay_field_d       = tx_delay_field_q;
		io_dir_d               = io_dir_q;
		io_data_d              = io_data_q;
		if (cmd_kind == cmd_write) begin
			// unused upper bits are dropped
			if (cmd_addr == `ADDR_TX_COARSE) begin
				tx_gain_coarse_field_d = wr_data_i[4:0];
			end else if (cmd_addr == `ADDR_TX_FINE) begin
				tx_gain_fine_field_d = wr_data_i[3:0];
			end else if (cmd_addr == `ADDR_RX_COARSE) begin
				rx_gain_coarse_field_d = wr_data_i[4:0];
			end else if (cmd_addr == `ADDR_RX_FINE) begin
				rx_gain_fine_field_d = wr_data_i[3:0];
			end else if (cmd_addr == `ADDR_RXS) begin
				rx_slot_field_d = wr_data_i[6:0];
			end else if (cmd_addr == `ADDR_RXD) begin
				rx_delay_field_d = wr_data_i[2:0];
			end else if (cmd_addr == `ADDR_TXS) begin
				tx_slot_field_d = wr_data_i[6:0];
			end else if (cmd_addr == `ADDR_TXD) begin
				tx_delay_field_d = wr_data_i[2:0];
			end else if (cmd_addr == `ADDR_GPIO) begin
				io_dir_d = wr_data_i[`GPIO_DIR_LSB +: IO_PINS];
				for (int i = 0; i < IO_PINS; i++) begin
					if (wr_data_i[`GPIO_DIR_LSB + i]) begin
						io_data_d[i] = wr_data_i[i];
					end
				end
			end
			// reserved and mode addresses ignore writes here
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_gain_coarse_field_q <= 5'h00;
			tx_gain_fine_field_q   <= 4'h0;
			rx_gain_coarse_field_q <= 5'h00;
			rx_gain_fine_field_q   <= 4'h0;
			rx_slot_field_q        <= 7'h00;
			rx_delay_field_q       <= 3'h0;
			tx_slot_field_q        <= 7'h00;
			tx_delay_field_q       <= 3'h0;
			io_dir_q               <= '0;
			io_data_q              <= '0;
		end else begin
			tx_gain_coarse_field_q <= tx_gain_coarse_field_d;
			tx_gain_fine_field_q   <= tx_gain_fine_field_d;
			rx_gain_coarse_field_q <= rx_gain_coarse_field_d;
			rx_gain_fine_field_q   <= rx_gain_fine_field_d;
			rx_slot_field_q        <= rx_slot_field_d;
			rx_delay_field_q       <= rx_delay_field_d;
			tx_slot_field_q        <= tx_slot_field_d;
			tx_delay_field_q       <= tx_delay_field_d;
			io_dir_q               <= io_dir_d;
			io_data_q              <= io_data_d;
		end
	end

	// read answer
	always_comb begin
		rd_valid_d = en_i ? 1'b0 : rd_valid_q;
		rd_data_d  = rd_data_q;
		if (cmd_kind == cmd_read) begin
			rd_valid_d = 1'b1;
			rd_data_d  = `READ_ZERO;
			if (cmd_addr == `ADDR_TX_COARSE) begin
				rd_data_d[4:0] = tx_gain_coarse_field_q;
			end else if (cmd_addr == `ADDR_TX_FINE) begin
				rd_data_d[3:0] = tx_gain_fine_field_q;
			end else if (cmd_addr == `ADDR_RX_COARSE) begin
				rd_data_d[4:0] = rx_gain_coarse_field_q;
			end else if (cmd_addr == `ADDR_RX_FINE) begin
				rd_data_d[3:0] = rx_gain_fine_field_q;
			end else if (cmd_addr == `ADDR_RXS) begin
				rd_data_d[6:0] = rx_slot_field_q;
			end else if (cmd_addr == `ADDR_RXD) begin
				rd_data_d[2:0] = rx_delay_field_q;
			end else if (cmd_addr == `ADDR_TXS) begin
				rd_data_d[6:0] = tx_slot_field_q;
			end else if (cmd_addr == `ADDR_TXD) begin
				rd_data_d[2:0] = tx_delay_field_q;
			end else if (cmd_addr == `ADDR_GPIO) begin
				rd_data_d = {io_dir_q, io_view};
			end
		end
	end

	// outputs to the analog gain stages, pcm framer and pins
	always_comb begin
		tx_db_d    = tx_db_q;
		tx_tenth_d = tx_tenth_q;
		tx_total_d = tx_total_q;
		rx_db_d    = rx_db_q;
		rx_tenth_d = rx_tenth_q;
		rx_total_d = rx_total_q;
		rx_slot_d  = rx_slot_q;
		rx_delay_d = rx_delay_q;
		tx_slot_d  = tx_slot_q;
		tx_delay_d = tx_delay_q;
		io_out_d   = io_out_q;
		io_oe_n_d  = io_oe_n_q;
		if (en_i) begin
			tx_db_d    = tx_g.coarse_sat;
			tx_tenth_d = tx_g.fine_sat;
			tx_total_d = tx_g.total;
			rx_db_d    = rx_g.coarse_sat;
			rx_tenth_d = rx_g.fine_sat;
			rx_total_d = rx_g.total;
			rx_slot_d  = rx_slot_field_q;
			rx_delay_d = rx_delay_field_q;
			tx_slot_d  = tx_slot_field_q;
			tx_delay_d = tx_delay_field_q;
			io_out_d   = io_data_q;
			io_oe_n_d  = ~io_dir_q;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rd_data_q  <= `READ_ZERO;
			rd_valid_q <= 1'b0;
			tx_db_q    <= 5'sh00;
			tx_tenth_q <= 4'h0;
			tx_total_q <= 9'sh000;
			rx_db_q    <= 5'sh00;
			rx_tenth_q <= 4'h0;
			rx_total_q <= 9'sh000;
			rx_slot_q  <= 7'h00;
			rx_delay_q <= 3'h0;
			tx_slot_q  <= 7'h00;
			tx_delay_q <= 3'h0;
			io_out_q   <= '0;
			io_oe_n_q  <= '1;
		end else begin
			rd_data_q  <= rd_data_d;
			rd_valid_q <= rd_valid_d;
			tx_db_q    <= tx_db_d;
			tx_tenth_q <= tx_tenth_d;
			tx_total_q <= tx_total_d;
			rx_db_q    <= rx_db_d;
			rx_tenth_q <= rx_tenth_d;
			rx_total_q <= rx_total_d;
			rx_slot_q  <= rx_slot_d;
			rx_delay_q <= rx_delay_d;
			tx_slot_q  <= tx_slot_d;
			tx_delay_q <= tx_delay_d;
			io_out_q   <= io_out_d;
			io_oe_n_q  <= io_oe_n_d;
		end
	end

	assign rd_data_o       = rd_data_q;
	assign rd_valid_o      = rd_valid_q;
	assign tx_gain_db_o    = tx_db_q;
	assign tx_gain_tenth_o = tx_tenth_q;
	assign tx_gain_total_o = tx_total_q;
	assign rx_gain_db_o    = rx_db_q;
	assign rx_gain_tenth_o = rx_tenth_q;
	assign rx_gain_total_o = rx_total_q;
	assign rx_slot_o       = rx_slot_q;
	assign rx_delay_o      = rx_delay_q;
	assign tx_slot_o       = tx_slot_q;
	assign tx_delay_o      = tx_delay_q;
	assign io_out_o        = io_out_q;
	assign io_oe_n_o       = io_oe_n_q;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_wr(logic [3:0] a);
		en_i && cmd_valid_i && cmd_byte_i == {`CMD_WRITE, a};
	endsequence

	sequence s_rd(logic [3:0] a);
		en_i && cmd_valid_i && cmd_byte_i == {`CMD_READ, a};
	endsequence

	a_tx_coarse_hi: assert property (
		s_wr(`ADDR_TX_COARSE) ##0 ($signed(wr_data_i[4:0]) > `COARSE_MAX) ##1 en_i
		|=> tx_gain_db_o == `COARSE_MAX)
		else $error("coarse transmit gain not held at +12");

	a_tx_coarse_lo: assert property (
		s_wr(`ADDR_TX_COARSE) ##0 ($signed(wr_data_i[4:0]) < `COARSE_MIN) ##1 en_i
		|=> tx_gain_db_o == `COARSE_MIN)
		else $error("coarse transmit gain not held at -12");

	a_tx_fine_clamp: assert property (
		s_wr(`ADDR_TX_FINE) ##0 (wr_data_i[3:0] > `FINE_MAX) ##1 en_i
		|=> tx_gain_tenth_o == `FINE_MAX)
		else $error("fine transmit gain not clamped to 9");

	a_tx_total_sum: assert property (
		int'(tx_gain_total_o) == int'(tx_gain_db_o) * 10 + int'(tx_gain_tenth_o))
		else $error("transmit total is not coarse plus tenths");

	a_rx_coarse_hi: assert property (
		s_wr(`ADDR_RX_COARSE) ##0 ($signed(wr_data_i[4:0]) > `COARSE_MAX) ##1 en_i
		|=> rx_gain_db_o == `COARSE_MAX)
		else $error("coarse receive gain not held at +12");

	a_rx_fine_clamp: assert property (
		s_wr(`ADDR_RX_FINE) ##0 (wr_data_i[3:0] > `FINE_MAX) ##1 en_i
		|=> rx_gain_tenth_o == `FINE_MAX)
		else $error("fine receive gain not clamped to 9");

	a_rx_total_sum: assert property (
		int'(rx_gain_total_o) == int'(rx_gain_db_o) * 10 + int'(rx_gain_tenth_o))
		else $error("receive total is not coarse plus tenths");

	a_rx_slot_load: assert property (
		s_wr(`ADDR_RXS) ##1 en_i |=> rx_slot_o == $past(wr_data_i[6:0], 2))
		else $error("receive slot output does not follow write");

	a_gpio_dir_oe: assert property (
		s_wr(`ADDR_GPIO) ##1 en_i |=> io_oe_n_o == ~$past(wr_data_i[7:4], 2))
		else $error("pin enables do not follow direction bits");

	a_gpio_read_view: assert property (
		s_rd(`ADDR_GPIO) |=> rd_valid_o && rd_data_o[3:0] ==
			(($past(io_data_q) & $past(io_dir_q)) | ($past(io_in_i) & ~$past(io_dir_q))))
		else $error("io pin read does not show pin levels");

	a_slot_upper_zero: assert property (
		s_rd(`ADDR_TXS) |=> rd_valid_o && !rd_data_o[7])
		else $error("unused slot bit reads nonzero");
endmodule // codec_regs

// ===== bench/host_model.sv
// host controller model: sends register commands and plays the io pin loads
// assumes the bank takes a command on the rising edge it sees it valid
`timescale 1ns/1ps
module host_model (
	input  wire logic                  clk_i,
	input  wire logic [3:0]            ext_lvl_i,
	input  wire logic [3:0]            io_out_i,
	input  wire logic [3:0]            io_oe_n_i,
	input  wire logic                  rd_valid_i,
	input  wire codec_regs_pkg::byte_t rd_data_i,
	output codec_regs_pkg::byte_t      cmd_byte_o,
	output codec_regs_pkg::byte_t      wr_data_o,
	output logic                       cmd_valid_o,
	output logic [3:0]                 io_in_o
);
	import codec_regs_pkg::*;
	// pin level: bank driver when enabled, else the external load
	assign io_in_o = (~io_oe_n_i & io_out_i) | (io_oe_n_i & ext_lvl_i);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_byte_o  = 8'h00;
		wr_data_o   = 8'h00;
	end
	// one command cycle; released lines show the inverse of the last value
	task automatic xfer(input byte_t cmd, input byte_t dat, output logic vld, output byte_t rdat);
		@(posedge clk_i);
		#1;
		cmd_valid_o = 1'b1;
		cmd_byte_o  = cmd;
		wr_data_o   = dat;
		@(posedge clk_i);
		#1;
		cmd_valid_o = 1'b0;
		cmd_byte_o  = ~cmd;
		wr_data_o   = ~dat;
		vld         = rd_valid_i;
		rdat        = rd_data_i;
	endtask
	task automatic wr(input logic [3:0] a, input byte_t d);
		logic  v;
		byte_t r;
		// reserved register is left alone
		if (a != 4'h9) begin
			xfer({4'hb, a}, d, v, r);
		end
	endtask
	task automatic rd(input logic [3:0] a, output logic v, output byte_t d);
		xfer({4'ha, a}, 8'h00, v, d);
	endtask
endmodule // host_model

// ===== bench/codec_gain_slot_gpio_regs_bench.sv
// self-checking bench of the codec register bank
// assumes host_model as the command source and io pin load
`timescale 1ns/1ps
module codec_gain_slot_gpio_regs_bench;
	import codec_regs_pkg::*;
	logic       clk_i;
	logic       nrst_i;
	logic       en_i;
	logic       cmd_valid_i;
	logic       rd_valid_o;
	byte_t      cmd_byte_i;
	byte_t      wr_data_i;
	byte_t      rd_data_o;
	logic [3:0] io_in_i;
	logic [3:0] io_out_o;
	logic [3:0] io_oe_n_o;
	logic [3:0] ext_lvl;
	db_t        tx_gain_db_o;
	db_t        rx_gain_db_o;
	tenth_t     tx_gain_tenth_o;
	tenth_t     rx_gain_tenth_o;
	gain_t      tx_gain_total_o;
	gain_t      rx_gain_total_o;
	slot_t      rx_slot_o;
	slot_t      tx_slot_o;
	delay_t     rx_delay_o;
	delay_t     tx_delay_o;
	int         error_cnt = 0;
	int         comparisons = 0;

	codec_regs #(.IO_PINS(4)) codec_regs_inst (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i),
		.cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i), .wr_data_i(wr_data_i),
		.io_in_i(io_in_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
		.tx_gain_db_o(tx_gain_db_o), .tx_gain_tenth_o(tx_gain_tenth_o),
		.tx_gain_total_o(tx_gain_total_o), .rx_gain_db_o(rx_gain_db_o),
		.rx_gain_tenth_o(rx_gain_tenth_o), .rx_gain_total_o(rx_gain_total_o),
		.rx_slot_o(rx_slot_o), .rx_delay_o(rx_delay_o), .tx_slot_o(tx_slot_o),
		.tx_delay_o(tx_delay_o), .io_out_o(io_out_o), .io_oe_n_o(io_oe_n_o));
	host_model host_model_inst (.clk_i(clk_i), .ext_lvl_i(ext_lvl), .io_out_i(io_out_o),
		.io_oe_n_i(io_oe_n_o), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
		.cmd_byte_o(cmd_byte_i), .wr_data_o(wr_data_i), .cmd_valid_o(cmd_valid_i),
		.io_in_o(io_in_i));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic test_done();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd_chk(input logic [3:0] a, input byte_t exp);
		logic  v;
		byte_t d;
		host_model_inst.rd(a, v, d);
		chk("read valid", 9'h001, {8'h00, v});
		chk("read data", {1'b0, exp}, {1'b0, d});
	endtask
	task automatic settle();
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	// reset state of pin enables, both slots, transmit total and of every register
	task automatic t_reset();
		chk("pin enables", 9'h00f, {5'h00, io_oe_n_o});
		chk("rx slot", 9'h000, {2'b00, rx_slot_o});
		chk("tx slot", 9'h000, {2'b00, tx_slot_o});
		chk("tx total", 9'h000, tx_gain_total_o);
		for (int a = 1; a <= 10; a++) begin
			rd_chk(4'(a), 8'h00);
		end
	endtask
	// saturation and clamp table on both paths, upper bits written as ones
	task automatic t_gain();
		logic [4:0] cv [6] = '{5'h1f, 5'h0c, 5'h10, 5'h0d, 5'h07, 5'h1c};
		logic [3:0] fv [6] = '{4'h9, 4'hf, 4'h0, 4'h3, 4'h3, 4'ha};
		int         edb [6] = '{-1, 12, -12, 12, 7, -4};
		int         etn [6] = '{9, 9, 0, 3, 3, 9};
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 6; i++) begin
				host_model_inst.wr(4'(1 + 2 * p), {3'b111, cv[i]});
				host_model_inst.wr(4'(2 + 2 * p), {4'hf, fv[i]});
				settle();
				rd_chk(4'(1 + 2 * p), {3'b000, cv[i]});
				rd_chk(4'(2 + 2 * p), {4'h0, fv[i]});
				chk("gain db", 9'(edb[i]), p ? rx_gain_db_o : tx_gain_db_o);
				chk("gain tenth", 9'(etn[i]), p ? rx_gain_tenth_o : tx_gain_tenth_o);
				chk("gain total", 9'(edb[i] * 10 + etn[i]),
					p ? rx_gain_total_o : tx_gain_total_o);
			end
		end
	endtask
	// slot and delay fields at their top values, then receive slot zero again and transmit slot 2a
	task automatic t_pcm();
		for (int a = 5; a <= 8; a++) begin
			host_model_inst.wr(4'(a), 8'hff);
			rd_chk(4'(a), a[0] ? 8'h7f : 8'h07);
		end
		settle();
		chk("rx slot", 9'h07f, {2'b00, rx_slot_o});
		chk("rx delay", 9'h007, {6'h00, rx_delay_o});
		chk("tx slot", 9'h07f, {2'b00, tx_slot_o});
		chk("tx delay", 9'h007, {6'h00, tx_delay_o});
		host_model_inst.wr(4'h5, 8'h00);
		host_model_inst.wr(4'h7, 8'h2a);
		settle();
		chk("rx slot", 9'h000, {2'b00, rx_slot_o});
		chk("tx slot", 9'h02a, {2'b00, tx_slot_o});
	endtask
	// unmapped places, bad type nibble and a frozen clock enable
	task automatic t_refuse();
		logic  v;
		byte_t d;
		rd_chk(4'h0, 8'h00);
		rd_chk(4'h9, 8'h00);
		host_model_inst.wr(4'hb, 8'h55);
		rd_chk(4'hb, 8'h00);
		host_model_inst.xfer(8'h57, 8'h00, v, d);
		chk("bad type valid", 9'h000, {8'h00, v});
		host_model_inst.xfer(8'hc7, 8'h00, v, d);
		rd_chk(4'h7, 8'h2a);
		// let the answer pulse end before freezing, a frozen pulse would stand
		@(posedge clk_i);
		#1;
		en_i = 1'b0;
		host_model_inst.wr(4'h7, 8'h11);
		host_model_inst.rd(4'h7, v, d);
		chk("frozen valid", 9'h000, {8'h00, v});
		chk("frozen data", 9'h02a, {1'b0, d});
		chk("frozen tx slot", 9'h02a, {2'b00, tx_slot_o});
		en_i = 1'b1;
		rd_chk(4'h7, 8'h2a);
	endtask
	// pins 0 and 1 out, 2 and 3 in; live levels, stored bits, mid-run reset
	task automatic t_gpio();
		ext_lvl = 4'b1010;
		host_model_inst.wr(4'ha, 8'h35);
		settle();
		chk("pin enables", 9'h00c, {5'h00, io_oe_n_o});
		chk("pin levels", 9'h001, {5'h00, io_out_o});
		rd_chk(4'ha, 8'h39);
		ext_lvl = 4'b1110;
		rd_chk(4'ha, 8'h3d);
		host_model_inst.wr(4'ha, 8'hf6);
		settle();
		chk("pin enables", 9'h000, {5'h00, io_oe_n_o});
		chk("pin levels", 9'h006, {5'h00, io_out_o});
		rd_chk(4'ha, 8'hf6);
		nrst_i = 1'b0;
		#1;
		chk("pin enables", 9'h00f, {5'h00, io_oe_n_o});
		@(posedge clk_i);
		#1;
		nrst_i = 1'b1;
		rd_chk(4'ha, 8'h0e);
	endtask

	initial begin
		repeat (5000) @(posedge clk_i);
		error_cnt++;
		test_done();
	end
	initial begin
		nrst_i  = 1'b0;
		en_i    = 1'b1;
		ext_lvl = 4'b0000;
		repeat (6) @(posedge clk_i);
		#1;
		nrst_i = 1'b1;
		t_reset();
		t_gain();
		t_pcm();
		t_refuse();
		t_gpio();
		test_done();
	end
endmodule // codec_gain_slot_gpio_regs_bench
